// *** pkg/clock_run_defines.vh ***
`ifndef CLOCK_RUN_DEFINES_VH
`define CLOCK_RUN_DEFINES_VH
// ****************************************
// register map
// ****************************************
`define CTRL_OFFSET 8'h3C
`define IRQ_STATUS_OFFSET 8'h44
`define IRQ_MASK_OFFSET 8'h48
`define CTRL_RESET 32'h00000000
// ****************************************
// control register fields
// ****************************************
`define STATUS_BIT 15
`define ENABLE_BIT 8
`define FUNC_SEL_BIT 0
// ****************************************
// interrupt status fields
// ****************************************
`define IRQ_REQ_DONE_BIT 0
`define IRQ_STATUS_SET_BIT 1
`define IRQ_WIDTH 2
// ****************************************
// handshake counts, in link clock rising edges
// ****************************************
`define HOLD_EDGES 2
`define IDLE_EDGES 2
`endif

// *** rtl/clock_run_ctrl.v ***
// Notes on behaviour
// - hard reset clears register; soft reset keeps it
// - status bit sticky, cleared by writing one
// - status and enable shared with config space
// - enable clear forces the shared pin inactive
// - enable bit loadable from configuration memory
// - select bit picks clock-run or power-event mode
// - clock-run output only drives low
// - line undriven except during a request
// - stop request with pending traffic: continue
// - clock stopped and wake or data: start
// - hold line two link edges, then release
// - need two idle-high edges before asserting
// - pending interrupt does not block clock stop
// - no requests without the enable bit
// - receive clock select follows the line in clock-run mode only
`timescale 1ns/10ps
`include "clock_run_defines.vh"
module clock_run_ctrl (
   input wire pclk,
   input wire presetn,
   input wire soft_reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire cfg_wr_status_clear,
   input wire cfg_wr_enable,
   input wire cfg_enable_value,
   input wire eeprom_load,
   input wire eeprom_enable_value,
   input wire power_event,
   input wire tx_rx_pending,
   input wire wake_packet,
   input wire rx_dma_ready,
   input wire pci_int_pending,
   input wire link_clk,
   input wire clock_run_line_in,
   output reg clock_run_line_out,
   output reg clock_run_line_oe,
   output reg rx_clk_sel_osc,
   output reg power_event_status,
   output reg power_event_enable,
   output reg irq
);
   // ****************************************
   // synchronisers
   // ****************************************
   reg [1:0] line_sync;
   reg [1:0] lclk_sync;
   reg lclk_prev;
   wire line_s = line_sync[1];
   wire link_rise = lclk_sync[1] & ~lclk_prev;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_sync <= 2'b11;
         lclk_sync <= 2'b00;
         lclk_prev <= 1'b0;
      end else begin
         line_sync <= {line_sync[0], clock_run_line_in};
         lclk_sync <= {lclk_sync[0], link_clk};
         lclk_prev <= lclk_sync[1];
      end
   end
   // ****************************************
   // register access
   // ****************************************
   reg func_sel;
   reg [`IRQ_WIDTH-1:0] irq_status;
   reg [`IRQ_WIDTH-1:0] irq_mask;
   wire wr = psel & penable & pwrite;
   wire rd = psel & penable & ~pwrite;
   wire hit_ctrl = paddr == `CTRL_OFFSET;
   wire hit_sts = paddr == `IRQ_STATUS_OFFSET;
   wire hit_msk = paddr == `IRQ_MASK_OFFSET;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~(hit_ctrl | hit_sts | hit_msk);
   wire sts_clr = (wr & hit_ctrl & pwdata[`STATUS_BIT]) | cfg_wr_status_clear;
   reg req_done;
   wire status_rise = power_event & ~power_event_status;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_event_status <= 1'b0;
         power_event_enable <= 1'b0;
         func_sel <= 1'b0;
         irq_mask <= {`IRQ_WIDTH{1'b0}};
         irq_status <= {`IRQ_WIDTH{1'b0}};
         prdata <= 32'h00000000;
      end else begin
         // soft reset leaves the register untouched
         if (power_event)
            power_event_status <= 1'b1;
         else if (sts_clr)
            power_event_status <= 1'b0;
         if (eeprom_load)
            power_event_enable <= eeprom_enable_value;
         else if (cfg_wr_enable)
            power_event_enable <= cfg_enable_value;
         else if (wr & hit_ctrl)
            power_event_enable <= pwdata[`ENABLE_BIT];
         if (wr & hit_ctrl)
            func_sel <= pwdata[`FUNC_SEL_BIT];
         if (wr & hit_msk)
            irq_mask <= pwdata[`IRQ_WIDTH-1:0];
         irq_status <= ((rd & hit_sts) ? {`IRQ_WIDTH{1'b0}} : irq_status)
            | {status_rise, req_done};
         prdata <= 32'h00000000;
         if (psel & ~penable & ~pwrite) begin
            if (hit_ctrl) begin
               prdata[`STATUS_BIT] <= power_event_status;
               prdata[`ENABLE_BIT] <= power_event_enable;
               prdata[`FUNC_SEL_BIT] <= func_sel;
            end else if (hit_sts)
               prdata[`IRQ_WIDTH-1:0] <= irq_status | {status_rise, req_done};
            else if (hit_msk)
               prdata[`IRQ_WIDTH-1:0] <= irq_mask;
         end
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end
   // ****************************************
   // clock-run handshake
   // ****************************************
   localparam ST_IDLE = 2'd0;
   localparam ST_DRIVE = 2'd1;
   localparam ST_WAIT = 2'd2;
   reg [1:0] state;
   reg [1:0] idle_cnt;
   reg [1:0] hold_cnt;
   // interrupt status is deliberately not a reason to request
   wire need = line_s ? (tx_rx_pending | wake_packet | rx_dma_ready) : 1'b0;
   wire may_req = func_sel & power_event_enable & ~soft_reset;
   wire pme_drive = ~func_sel & power_event_enable & power_event_status;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         idle_cnt <= 2'd0;
         hold_cnt <= 2'd0;
         req_done <= 1'b0;
      end else begin
         req_done <= 1'b0;
         if (link_rise)
            idle_cnt <= !line_s ? 2'd0 :
               (idle_cnt == `IDLE_EDGES ? idle_cnt : idle_cnt + 2'd1);
         case (state)
            ST_IDLE: begin
               if (may_req & need & (idle_cnt == `IDLE_EDGES)) begin
                  state <= ST_DRIVE;
                  hold_cnt <= 2'd0;
               end
            end
            ST_DRIVE: begin
               if (!may_req)
                  state <= ST_IDLE;
               else if (link_rise) begin
                  if (hold_cnt == `HOLD_EDGES - 1) begin
                     state <= ST_WAIT;
                     req_done <= 1'b1;
                  end
                  hold_cnt <= hold_cnt + 2'd1;
               end
            end
            ST_WAIT: begin
               // wait for the resource to release the line
               if (line_s) begin
                  state <= ST_IDLE;
                  idle_cnt <= 2'd0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   // ****************************************
   // pin drive and receive clock select
   // ****************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_run_line_out <= 1'b0;
         clock_run_line_oe <= 1'b0;
         rx_clk_sel_osc <= 1'b0;
      end else begin
         clock_run_line_out <= 1'b0;
         clock_run_line_oe <= func_sel ? (state == ST_DRIVE && may_req) : pme_drive;
         rx_clk_sel_osc <= func_sel & line_s;
      end
   end
endmodule // clock_run_ctrl

// *** verification/clock_resource.sv ***
`timescale 1ns/10ps
module clock_resource (
   input wire want_stop,
   input wire dev_oe,
   output logic link_clk,
   output wire line
);
   logic res_low = 1'b1;
   initial link_clk = 1'b0;
   // pulled up: low while either side pulls it down
   assign line = !(res_low || dev_oe);
   always begin
      #80 link_clk = !link_clk;
      if (!res_low) #160;
   end
   always begin
      wait (want_stop && !dev_oe);
      res_low = 1'b0;
      wait (dev_oe || !want_stop);
      res_low = 1'b1;
      repeat (4) @(posedge link_clk);
   end
endmodule // clock_resource

// *** verification/clock_run_ctrl_tb.sv ***
`timescale 1ns/10ps
`include "clock_run_defines.vh"
module clock_run_ctrl_tb;
   logic pclk = 0, presetn = 0, soft_reset = 0, psel = 0, penable = 0, pwrite = 0, power_event = 0;
   logic cfg_wr_status_clear = 0, cfg_wr_enable = 0, cfg_enable_value = 0, eeprom_load = 0;
   logic eeprom_enable_value = 0, tx_rx_pending = 0, wake_packet = 0, rx_dma_ready = 0;
   logic pci_int_pending = 0, want_stop = 0, seen = 0;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, r;
   logic slv = 0;
   wire [31:0] prdata;
   wire pready, pslverr, link_clk, clock_run_line_in, clock_run_line_out, clock_run_line_oe;
   wire rx_clk_sel_osc, power_event_status, power_event_enable, irq;
   int err_total = 0, cmp_count = 0, cyc = 0;
   clock_run_ctrl dut_u (.*);
   clock_resource cr_u (.want_stop(want_stop), .dev_oe(clock_run_line_oe), .link_clk(link_clk),
      .line(clock_run_line_in));
   always #5 pclk = !pclk;
   task tick(int n);
      repeat (n) @(posedge pclk);
   endtask
   task chk(logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("[ERR] check %0d exp %h got %h", cmp_count, e, s);
      end
   endtask
   task apb(logic w, logic [7:0] a, logic [31:0] d);
      tick(1);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1;
      do tick(1); while (pready !== 1'b1);
      r = prdata;
      slv = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rd(logic [7:0] a, logic [31:0] e);
      apb(0, a, 0);
      chk(e, r);
   endtask
   task woe(logic v);
      for (int k = 0; k < 400 && clock_run_line_oe !== v; k++) tick(1);
      chk(v, clock_run_line_oe);
   endtask
   task summarize;
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (clock_run_line_oe) seen <= 1;
      if (cyc > 20000) begin
         err_total++;
         summarize;
      end
   end
   initial begin
      tick(8);
      presetn <= 1;
      rd(`CTRL_OFFSET, `CTRL_RESET);
      rd(8'h10, 0);
      chk(1, slv);
      rd(`CTRL_OFFSET, 0);
      chk(0, slv);
      eeprom_enable_value <= 1;
      eeprom_load <= 1;
      tick(1);
      eeprom_load <= 0;
      rd(`CTRL_OFFSET, 32'h100);
      apb(1, `IRQ_MASK_OFFSET, 32'h3);
      power_event <= 1;
      tick(1);
      power_event <= 0;
      tick(3);
      chk(1, clock_run_line_oe);
      chk(1, irq);
      rd(`CTRL_OFFSET, 32'h8100);
      rd(`IRQ_STATUS_OFFSET, 32'h2);
      rd(`IRQ_STATUS_OFFSET, 0);
      cfg_enable_value <= 0;
      cfg_wr_enable <= 1;
      cfg_wr_status_clear <= 1;
      tick(1);
      cfg_wr_enable <= 0;
      cfg_wr_status_clear <= 0;
      rd(`CTRL_OFFSET, 0);
      apb(1, `CTRL_OFFSET, 32'hFFFF8001);
      rd(`CTRL_OFFSET, 32'h1);
      soft_reset <= 1;
      tick(2);
      soft_reset <= 0;
      rd(`CTRL_OFFSET, 32'h1);
      want_stop <= 1;
      tx_rx_pending <= 1;
      pci_int_pending <= 1;
      seen <= 0;
      tick(500);
      chk(1, rx_clk_sel_osc);
      tx_rx_pending <= 0;
      apb(1, `CTRL_OFFSET, 32'h101);
      tick(500);
      chk(0, seen);
      for (int i = 0; i < 3; i++) begin
         {tx_rx_pending, wake_packet, rx_dma_ready} <= 3'h4 >> i;
         woe(1);
         woe(0);
         chk(0, rx_clk_sel_osc);
         {tx_rx_pending, wake_packet, rx_dma_ready} <= 0;
         want_stop <= 0;
         rd(`IRQ_STATUS_OFFSET, 32'h1);
         tick(100);
         want_stop <= 1;
         tick(200);
      end
      summarize;
   end
endmodule // clock_run_ctrl_tb
bind clock_run_ctrl clock_run_props chk_u (.*);

// *** verification/clock_run_props_properties.sv ***
`timescale 1ns/10ps
module clock_run_props (
   input wire pclk, presetn, psel, penable, pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire eeprom_load, eeprom_enable_value, cfg_wr_enable, cfg_wr_status_clear, power_event,
   input wire clock_run_line_out, clock_run_line_oe, power_event_status, power_event_enable, irq
);
   wire wr = psel & penable & pwrite & (paddr == 8'h3C);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_out_low: assert property (!clock_run_line_out)
      else $error("line driven high");
   a_off_quiet: assert property (!power_event_enable [*3] |-> !clock_run_line_oe)
      else $error("pin active while disabled");
   a_rst_clear: assert property ($rose(presetn) |-> !power_event_status && !power_event_enable)
      else $error("register not clear after reset");
   a_sts_sticky: assert property (power_event_status && !cfg_wr_status_clear
      && !(wr && pwdata[15]) |=> power_event_status) else $error("status lost");
   a_sts_set: assert property (power_event |-> ##[1:3] power_event_status)
      else $error("status not set");
   a_sts_clear: assert property (wr && pwdata[15] && !power_event |=> !power_event_status)
      else $error("status not cleared");
   a_en_write: assert property (wr && !eeprom_load && !cfg_wr_enable
      |=> power_event_enable == $past(pwdata[8])) else $error("enable not written");
   a_en_preset: assert property (eeprom_load |=> power_event_enable == $past(eeprom_enable_value))
      else $error("enable not preset");
   cover property (clock_run_line_oe && power_event_enable);
   cover property ($fell(irq));
   cover property (wr && pwdata[15]);
endmodule // clock_run_props
